// ### rtl/ecs_pkg.sv
/*
  Constants for the external memory chip-select decoder.
  Assumes a 22-bit word address on the external 16-bit bus.
*/
package ecs_pkg;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned MAP_W  = 2;
  localparam int unsigned SEL_CNT = 3;
  // map settings
  localparam logic [1:0] MAP_SINGLE = 2'h0;
  localparam logic [1:0] MAP_HALVES = 2'h1;
  localparam logic [1:0] MAP_THREE  = 2'h2;
  localparam logic [1:0] MAP_THREE2 = 2'h3;
  // range ends, word addresses
  localparam logic [21:0] END_128M = 22'h3FFFFF;
  localparam logic [21:0] END_64M  = 22'h1FFFFF;
  localparam logic [21:0] END_32M  = 22'h0FFFFF;
  localparam logic [21:0] BASE_HI  = 22'h200000;
  localparam logic [21:0] BASE_Q2  = 22'h100000;
  localparam logic [21:0] BASE_LO  = 22'h000000;
  // select vector bit positions and idle value
  localparam int unsigned SEL_ROM  = 0;
  localparam int unsigned SEL_RAM  = 1;
  localparam int unsigned SEL_ROM2 = 2;
  localparam logic [2:0] SEL_NONE  = 3'h0;
  // deselected level, also the reset value of every select and of the shared pin
  localparam logic       SEL_OFF_N = 1'h1;
endpackage : ecs_pkg

// ### rtl/ecs_decode.sv
/*
  External chip-select decoder: maps a CPU external access address to one of
  three active-low memory selects. Assumes addr, access and map setting come
  from logic on clk; selects appear one cycle after the request.
*/
`timescale 1ns/1ns
// Notes on behaviour
// R01: provide primary ROM, RAM and second ROM selects; second ROM shares port C bit 7.
// R02: map 0 gives primary ROM the whole range 000000..3FFFFF only.
// R03: map 1 gives primary ROM 000000..1FFFFF; second ROM unused.
// R04: 200000..3FFFFF goes to RAM in map 1, second ROM in maps 2 and 3.
// R05: maps 2 and 3 give primary ROM 000000..0FFFFF.
// R06: maps 2 and 3 give RAM 100000..1FFFFF; both maps decode alike.
// R07: boundaries are word addresses on the 16-bit external bus.
// R08: at most one select low, only during an in-range external access.
module ecs_decode (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ext_access,
  input  wire logic [ecs_pkg::ADDR_W-1:0] word_addr,
  input  wire logic [ecs_pkg::MAP_W-1:0]  select_map_setting,
  input  wire logic                      port_c_bit7_gpio,
  output logic                           primary_rom_select_n,
  output logic                           ram_select_n,
  output logic                           second_rom_select_n,
  output logic                           port_c_bit7_pin
);
  import ecs_pkg::*;

  // decoded select request, one bit per chip, applied at the next edge
  logic [SEL_CNT-1:0] sel_nxt;
  logic               rom2_used_nxt;
  logic               pin_nxt;

  // inclusive window test on a word address
  function automatic logic in_range(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] lo,
    input logic [ADDR_W-1:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // maps that lend port C bit 7 to the second ROM
  function automatic logic rom2_on_pin(input logic [MAP_W-1:0] map);
    return (map == MAP_THREE) || (map == MAP_THREE2);
  endfunction : rom2_on_pin

  // ranges are compared as word addresses of the 16-bit bus, never byte addresses
  function automatic logic [SEL_CNT-1:0] decode_sel(
    input logic [MAP_W-1:0]  map,
    input logic [ADDR_W-1:0] a // R07
  );
    logic [SEL_CNT-1:0] s;
    s = SEL_NONE;
    case (map)
      MAP_SINGLE: begin
        if (in_range(a, BASE_LO, END_128M)) begin
          s[SEL_ROM] = 1'h1; // R02
        end
      end
      MAP_HALVES: begin
        if (in_range(a, BASE_LO, END_64M)) begin
          s[SEL_ROM] = 1'h1; // R03
        end else if (in_range(a, BASE_HI, END_128M)) begin
          s[SEL_RAM] = 1'h1; // R04
        end
      end
      MAP_THREE, MAP_THREE2: begin
        if (in_range(a, BASE_LO, END_32M)) begin
          s[SEL_ROM] = 1'h1; // R05
        end else if (in_range(a, BASE_Q2, END_64M)) begin
          s[SEL_RAM] = 1'h1; // R06
        end else if (in_range(a, BASE_HI, END_128M)) begin
          s[SEL_ROM2] = 1'h1; // R04
        end
      end
      default: begin
        s = SEL_NONE;
      end
    endcase
    return s;
  endfunction : decode_sel

  // an idle bus cycle leaves every chip deselected
  always_comb begin
    sel_nxt = SEL_NONE;
    if (ext_access) begin
      sel_nxt = decode_sel(select_map_setting, word_addr); // R08
    end
    rom2_used_nxt = rom2_on_pin(select_map_setting);
    pin_nxt = port_c_bit7_gpio;
    if (rom2_used_nxt) begin
      pin_nxt = ~sel_nxt[SEL_ROM2]; // R01
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_rom_select_n <= SEL_OFF_N;
      ram_select_n         <= SEL_OFF_N;
      second_rom_select_n  <= SEL_OFF_N;
    end else begin
      primary_rom_select_n <= ~sel_nxt[SEL_ROM]; // R01
      ram_select_n         <= ~sel_nxt[SEL_RAM]; // R01
      second_rom_select_n  <= ~sel_nxt[SEL_ROM2]; // R01
    end
  end

  // port C bit 7 carries the second ROM select in maps 2 and 3, else the gpio level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_c_bit7_pin <= SEL_OFF_N;
    end else begin
      port_c_bit7_pin <= pin_nxt; // R01
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_one_select: assert property ( // R08
    $countones({~primary_rom_select_n, ~ram_select_n, ~second_rom_select_n}) <= 1)
    else $error("more than one select active");

  a_idle_no_select: assert property ( // R08
    !ext_access
    |=> primary_rom_select_n && ram_select_n && second_rom_select_n)
    else $error("select active without access");

  a_access_hits: assert property ( // R08
    ext_access
    |=> $countones({~primary_rom_select_n, ~ram_select_n, ~second_rom_select_n}) == 1)
    else $error("access decoded to no select");

  a_sel_needs_access: assert property ( // R08
    !(primary_rom_select_n && ram_select_n && second_rom_select_n)
    |-> $past(ext_access))
    else $error("select low after a cycle without access");

  a_map0_rom: assert property ( // R02
    ext_access && select_map_setting == MAP_SINGLE
    |=> !primary_rom_select_n && ram_select_n && second_rom_select_n)
    else $error("map 0 decode wrong");

  a_ram_not_map0: assert property ( // R02
    !ram_select_n
    |-> $past(select_map_setting) != MAP_SINGLE)
    else $error("ram select in map 0");

  a_map1_low: assert property ( // R03
    ext_access && select_map_setting == MAP_HALVES && word_addr <= END_64M
    |=> !primary_rom_select_n && ram_select_n && second_rom_select_n)
    else $error("map 1 low half not primary rom");

  a_map1_no_rom2: assert property ( // R03
    select_map_setting == MAP_HALVES
    |=> second_rom_select_n)
    else $error("second rom select in map 1");

  a_rom_low: assert property ( // R03
    !primary_rom_select_n && $past(select_map_setting) != MAP_SINGLE
    |-> $past(word_addr) <= END_64M)
    else $error("primary rom select above low half");

  a_map1_high: assert property ( // R04
    ext_access && select_map_setting == MAP_HALVES && word_addr >= BASE_HI
    |=> !ram_select_n && primary_rom_select_n && second_rom_select_n)
    else $error("map 1 high half not ram");

  a_map3_high: assert property ( // R04
    ext_access && rom2_on_pin(select_map_setting) && word_addr >= BASE_HI
    |=> !second_rom_select_n && !port_c_bit7_pin && primary_rom_select_n && ram_select_n)
    else $error("maps 2/3 high not second rom");

  a_rom2_maps23: assert property ( // R04
    !second_rom_select_n
    |-> rom2_on_pin($past(select_map_setting)))
    else $error("second rom select outside maps 2/3");

  a_rom2_range: assert property ( // R04
    !second_rom_select_n
    |-> $past(word_addr) >= BASE_HI)
    else $error("second rom select below high half");

  a_map3_q0: assert property ( // R05
    ext_access && rom2_on_pin(select_map_setting) && word_addr <= END_32M
    |=> !primary_rom_select_n && ram_select_n && second_rom_select_n)
    else $error("maps 2/3 first quarter wrong");

  a_map3_q1: assert property ( // R06
    ext_access && rom2_on_pin(select_map_setting) && in_range(word_addr, BASE_Q2, END_64M)
    |=> !ram_select_n && primary_rom_select_n && second_rom_select_n)
    else $error("maps 2/3 second quarter wrong");

  a_ram_range: assert property ( // R06
    !ram_select_n
    |-> in_range($past(word_addr), BASE_Q2, END_128M))
    else $error("ram select in first quarter");

  a_word_top: assert property ( // R07
    ext_access && select_map_setting != MAP_SINGLE && word_addr == END_128M
    |=> primary_rom_select_n)
    else $error("top word address on primary rom");

  a_gpio_pass: assert property ( // R01
    !rom2_on_pin(select_map_setting)
    |=> port_c_bit7_pin == $past(port_c_bit7_gpio))
    else $error("port c bit 7 gpio not passed");

  a_pin_mirror: assert property ( // R01
    rom2_on_pin(select_map_setting)
    |=> port_c_bit7_pin == second_rom_select_n)
    else $error("port c bit 7 not second rom select");

  a_pin_idle: assert property ( // R01
    rom2_on_pin(select_map_setting) && !ext_access
    |=> port_c_bit7_pin)
    else $error("port c bit 7 low without access");

  c_rom: cover property (ext_access && select_map_setting == MAP_SINGLE);
  c_ram: cover property (!ram_select_n);
  c_rom2: cover property (!second_rom_select_n);
  c_back: cover property (!ram_select_n ##1 !primary_rom_select_n);
  c_pin_gpio: cover property (!rom2_on_pin(select_map_setting) && port_c_bit7_gpio ##1 port_c_bit7_pin);
endmodule : ecs_decode

// ### sim/ecs_mem_model.sv
/* memory chips on the three selects; assumes active-low selects */
`timescale 1ns/1ns
module ecs_mem_model (
  input wire logic  rom_n,
  input wire logic  ram_n,
  input wire logic  rom2_n,
  output logic [1:0] live
);
  // count of chips selected at once
  assign live = 2'(!rom_n) + 2'(!ram_n) + 2'(!rom2_n);
endmodule : ecs_mem_model

// ### sim/external_chip_select_decode_test.sv
/* self-checking bench for ecs_decode; assumes selects appear one cycle after inputs */
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin bad_count++; $display("Error %s exp %h got %h", n, e, s); end end
module external_chip_select_decode_test;
  import ecs_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, acc = 1'h0, gpio = 1'h0;
  logic [21:0] wa = '0;
  logic [1:0] map = '0;
  logic [3:0] exp_v = 4'h7;
  logic rom_n, ram_n, rom2_n, pin;
  logic [1:0] live;
  int bad_count = 0, check_count = 0, cyc = 0, seed = 32'hE6B7;
  logic [21:0] corner [6] = '{22'h0, 22'h0FFFFF, 22'h100000, 22'h1FFFFF, 22'h200000, 22'h3FFFFF};
  always #5 clk = ~clk;
  ecs_decode dut (.clk(clk), .rst_n(rst_n), .ext_access(acc), .word_addr(wa), .select_map_setting(map),
    .port_c_bit7_gpio(gpio), .primary_rom_select_n(rom_n), .ram_select_n(ram_n),
    .second_rom_select_n(rom2_n), .port_c_bit7_pin(pin));
  ecs_mem_model chips (.rom_n(rom_n), .ram_n(ram_n), .rom2_n(rom2_n), .live(live));
  // expected {pin, second rom, ram, primary rom}
  function automatic logic [3:0] exp_f(logic a, logic [21:0] w, logic [1:0] m, logic g);
    logic [2:0] s;
    s = 3'h7;
    if (a && m == MAP_SINGLE) s[0] = 1'b0;
    else if (a && w >= BASE_HI) s[m[1] ? 2 : 1] = 1'b0;
    else if (a && m[1] && w >= BASE_Q2) s[1] = 1'b0;
    else if (a) s[0] = 1'b0;
    return {m[1] ? s[2] : g, s};
  endfunction : exp_f
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic step(logic a, logic [21:0] w, logic [1:0] m, logic g);
    @(negedge clk);
    `CHK("selects", exp_v[2:0], {rom2_n, ram_n, rom_n})
    `CHK("pc7", exp_v[3], pin)
    `CHK("one_live", live <= 2'h1, 1'b1)
    exp_v = exp_f(a, w, m, g);
    acc = a;
    wa = w;
    map = m;
    gpio = g;
  endtask : step
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 24; i++) step(1'b1, corner[i % 6], 2'(i / 6), i[0]);
    $display("corner test done");
    step(1'b0, 22'h0, 2'h0, 1'b0);
    rst_n = 1'h0;
    @(negedge clk);
    `CHK("in_reset", 4'hF, {pin, rom2_n, ram_n, rom_n})
    rst_n = 1'h1;
    $display("reset test done");
    for (int i = 0; i < 400; i++) step(1'($random(seed)), 22'($random(seed)), 2'($random(seed)), 1'($random(seed)));
    step(1'b0, 22'h0, 2'h0, 1'b0);
    $display("random test done");
    close_out();
  end
endmodule : external_chip_select_decode_test
